// ===== aps_host_model.sv
// Purpose: host side issuing channel state writes
// Assumes: one write per go pulse
// Notes:   request code is not held once the strobe drops
`timescale 1ns/10ps
module aps_host_model (
    input  wire logic       i_ref_clk,         // clock
    input  wire logic       i_go,              // issue a write
    input  wire logic [7:0] i_code,            // two-bit code per channel
    output logic            o_st_wr = 1'b0,    // write strobe
    output logic [7:0]      o_st_req = 8'h00   // requested states
);
    always @(posedge i_ref_clk) begin
        o_st_wr <= i_go;
        o_st_req <= i_go ? i_code : ~o_st_req;
    end
endmodule

// ===== aps_params.svh
// Purpose: constants of the amplifier protection and state control block
// Assumes: attenuation is counted in 0.05dB units
// Notes:   included by its bare name
`ifndef APS_PARAMS_SVH
`define APS_PARAMS_SVH
`define APS_NCH      4
`define APS_NLVL     3
`define APS_AW       10
`define APS_HW       12
// host-side defaults for the step ports, 0.25dB and 0.1dB
`define APS_ATK_DEF  10'h005
`define APS_REL_DEF  10'h002
// latched event memory bits
`define APS_L_OVERTEMP_SHUTDOWN   0
`define APS_L_OC     1
`define APS_L_DC     2
`define APS_L_LIVE   3
`define APS_L_CLK    4
`define APS_L_CP     5
`define APS_L_PWR    6
`define APS_L_OTW    7
`define APS_L_CLIP   8
`define APS_NLAT     9
// configurable pin function codes
`define APS_FW       3
`define APS_F_OFF    3'h0
`define APS_F_FSIG   3'h1
`define APS_F_WSIG   3'h2
`define APS_F_CLKOUT 3'h3
`define APS_F_SYNCIN 3'h4
// clock alignment source
`define APS_S_NONE   2'h0
`define APS_S_PIN    2'h1
`define APS_S_SCLK   2'h2
// host state requests
`define APS_R_LDG    2'h0
`define APS_R_SLEEP  2'h1
`define APS_R_HIZ    2'h2
`define APS_R_PLAY   2'h3
`endif

// ===== aps_pkg.sv
// Purpose: types of the amplifier protection and state control block
// Assumes: nothing
// Notes:   channel state codes are reported on o_ch_state
package aps_pkg;
    typedef enum logic [2:0] {
        ST_LDG   = 3'b000,
        ST_SLEEP = 3'b001,
        ST_HIZ   = 3'b010,
        ST_PLAY  = 3'b011,
        ST_FAULT = 3'b100,
        ST_AREC  = 3'b101
    } aps_state_e;
endpackage

// ===== aps_protect_ctrl.sv
// Purpose: thermal gain reduction, fault/warning reporting, pins, channel states
// Assumes: all inputs except the async i_rst synchronous to i_ref_clk; i_sample_stb one pulse per sample
// Notes:   no register bus; configuration arrives on plain ports
`include "aps_params.svh"
`timescale 1ns/10ps
module aps_protect_ctrl #(
    parameter int NCH  = `APS_NCH,
    parameter int NLVL = `APS_NLVL,
    parameter int AW   = `APS_AW,
    parameter int HW   = `APS_HW
) (
    input  wire logic              i_ref_clk,       // clock
    input  wire logic              i_rst,           // async reset
    input  wire logic              i_pd_n,          // power-down pin, low active
    input  wire logic              i_standby_n_pin_n,        // standby pin, low active
    input  wire logic              i_sample_stb,    // one pulse per sample
    input  wire logic [NCH*NLVL-1:0] i_fb_hot,      // channel above level
    input  wire logic [NLVL*AW-1:0] i_fb_max,       // ceiling per level
    input  wire logic [AW-1:0]     i_fb_attack,     // attack step
    input  wire logic [AW-1:0]     i_fb_release,    // release step
    input  wire logic [HW-1:0]     i_fb_hold,       // hold samples
    output logic [NCH*AW-1:0]      o_fb_atten,      // attenuation per channel
    input  wire logic              i_otw_glob,      // global temp warning
    input  wire logic [NCH-1:0]    i_otw_ch,        // channel temp warning
    input  wire logic              i_overtemp_shutdown_glob,     // global temp shutdown
    input  wire logic [NCH-1:0]    i_overtemp_shutdown_ch,       // channel temp shutdown
    input  wire logic              i_overtemp_shutdown_self_recovery_state,  // temp shutdown recovers
    input  wire logic [NCH-1:0]    i_ocsd_ch,       // overcurrent shutdown
    input  wire logic [NCH-1:0]    i_oclim_ch,      // overcurrent limiting
    input  wire logic [NCH-1:0]    i_dc_ch,         // DC offset event
    input  wire logic [NCH-1:0]    i_live_flt_ch,   // live load check fault
    input  wire logic [NCH-1:0]    i_clip_ch,       // clip detect
    input  wire logic [NCH-1:0]    i_ldg_pass_ch,   // DC diag passed
    input  wire logic [NCH-1:0]    i_ldg_fail_ch,   // DC diag failed
    input  wire logic              i_vbat_uv,       // battery undervoltage
    input  wire logic              i_power_stage_supply_uv,       // power stage undervoltage
    input  wire logic              i_power_stage_supply_ov,       // power stage overvoltage
    input  wire logic              i_digital_supply_uv,       // digital supply undervoltage
    input  wire logic              i_cp_uv,         // charge pump supply fault
    input  wire logic              i_digital_supply_por_off,  // digital supply below POR
    input  wire logic              i_cp_fault,      // charge pump fault
    input  wire logic              i_clk_err,       // clock error
    input  wire logic [`APS_NLAT-1:0] i_mem_clr,    // clear latched events
    output logic [`APS_NLAT-1:0]   o_mem,           // latched events
    input  wire logic [2:0]        i_fpin_mask,     // mask default pin sources
    input  wire logic [5:0]        i_fpin_add,      // extra pin sources
    input  wire logic              i_fsig_pin_off,  // fault signal off the pin
    input  wire logic [8:0]        i_fsig_en,       // fault signal sources
    input  wire logic [7:0]        i_wsig_en,       // warning signal sources
    output logic                   o_fault_o,       // fault pin level
    output logic                   o_fault_oe,      // fault pin pull low
    output logic                   o_global_fault,  // any fault
    output logic                   o_fault_sig,     // enabled faults
    output logic                   o_global_warn,   // any warning except clock error
    output logic                   o_warn_sig,      // enabled warnings
    output logic                   o_temp_warn,     // temperature warning
    input  wire logic [2*`APS_FW-1:0] i_gpio_func,  // pin function codes
    input  wire logic [1:0]        i_gpio_i,        // pin inputs
    output logic [1:0]             o_gpio_o,        // pin outputs
    output logic [1:0]             o_gpio_oe,       // pin drive enables
    input  wire logic              i_ramp_clk,      // internal ramp clock
    input  wire logic              i_ss_clk,        // spread ramp clock
    input  wire logic              i_ss_en,         // spread spectrum on
    input  wire logic              i_sclk,          // audio bit clock
    input  wire logic [1:0]        i_sync_sel,      // alignment source
    output logic                   o_ramp_sync,     // alignment pulse
    input  wire logic              i_st_wr,         // state request strobe
    input  wire logic [2*NCH-1:0]  i_st_req,        // requested state per channel
    output logic [3*NCH-1:0]       o_ch_state,      // channel states
    output logic [NCH-1:0]         o_ch_switch,     // output stage switching
    output logic [NCH-1:0]         o_ch_dsp,        // processing running
    output logic                   o_shutdown,      // device shutdown
    output logic                   o_deep_sleep,    // deep sleep
    output logic                   o_prot_sd        // protective shutdown
);
    if (NCH < 1 || NLVL < 1 || AW < 2 || HW < 1) begin : g_chk
        $error("aps_protect_ctrl: bad parameters");
    end

    logic       clr;
    logic       pwr_fail;
    logic [`APS_NLAT-1:0] live;
    logic [`APS_NLAT-1:0] mem_q;
    logic [8:0] fsrc;
    logic [7:0] wsrc;
    logic       any_fault_st;
    logic       fsig;
    logic       gwarn;
    logic       wsig;
    logic       pin_drv;
    logic       sync_src;
    logic       sync_q;
    logic       fault_oe_q;
    logic       fsig_q;
    logic       wsig_q;
    logic       gfault_q;
    logic       gwarn_q;
    logic       twarn_q;
    logic       sync_pulse_q;
    logic [1:0] gpio_o_q;
    logic [1:0] gpio_oe_q;
    logic [NCH-1:0] in_fault;

    assign clr = ~i_pd_n | i_digital_supply_por_off;
    assign pwr_fail = i_vbat_uv | i_power_stage_supply_uv | i_power_stage_supply_ov | i_digital_supply_uv | i_cp_uv;

    always_comb begin
        live = '0;
        live[`APS_L_OVERTEMP_SHUTDOWN] = i_overtemp_shutdown_glob | (|i_overtemp_shutdown_ch);
        live[`APS_L_OC]   = |(i_ocsd_ch | i_oclim_ch);
        live[`APS_L_DC]   = |i_dc_ch;
        live[`APS_L_LIVE] = |i_live_flt_ch;
        live[`APS_L_CLK]  = i_clk_err;
        live[`APS_L_CP]   = i_cp_fault;
        live[`APS_L_PWR]  = pwr_fail;
        live[`APS_L_OTW]  = i_otw_glob | (|i_otw_ch);
        live[`APS_L_CLIP] = |i_clip_ch;
    end

    // event memory: a new event wins over i_mem_clr in the same cycle; clr wins over both
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mem_q <= '0;
        end else if (clr) begin
            mem_q <= '0;
        end else begin
            mem_q <= (mem_q & ~i_mem_clr) | live;
        end
    end
    assign o_mem = mem_q;

    always_comb begin
        fsrc[0] = live[`APS_L_PWR] | mem_q[`APS_L_PWR];
        fsrc[1] = live[`APS_L_OVERTEMP_SHUTDOWN] | mem_q[`APS_L_OVERTEMP_SHUTDOWN];
        fsrc[2] = |i_ldg_fail_ch;
        fsrc[3] = mem_q[`APS_L_OC];
        fsrc[4] = mem_q[`APS_L_DC];
        fsrc[5] = any_fault_st;
        fsrc[6] = mem_q[`APS_L_LIVE];
        fsrc[7] = mem_q[`APS_L_CLK];
        fsrc[8] = mem_q[`APS_L_CP];
        wsrc[0] = fsrc[0];
        wsrc[1] = fsrc[1];
        wsrc[2] = live[`APS_L_OTW] | mem_q[`APS_L_OTW];
        wsrc[3] = fsrc[2];
        wsrc[4] = (|i_oclim_ch) | mem_q[`APS_L_OC];
        wsrc[5] = live[`APS_L_CLIP] | mem_q[`APS_L_CLIP];
        wsrc[6] = mem_q[`APS_L_LIVE];
        wsrc[7] = mem_q[`APS_L_CLK];
    end

    assign any_fault_st = |in_fault;
    assign fsig  = |(fsrc & i_fsig_en);
    assign gwarn = |wsrc[6:0];
    assign wsig  = |(wsrc & i_wsig_en);

    // masks touch only the pin term, never fsrc, wsrc or the channel states
    always_comb begin
        pin_drv = 1'b0;
        pin_drv |= fsrc[1] & ~i_fpin_mask[0];
        pin_drv |= mem_q[`APS_L_OC] & ~i_fpin_mask[1];
        pin_drv |= mem_q[`APS_L_DC] & ~i_fpin_mask[2];
        pin_drv |= fsrc[0] & i_fpin_add[0];
        pin_drv |= fsrc[2] & i_fpin_add[1];
        pin_drv |= (live[`APS_L_LIVE] | mem_q[`APS_L_LIVE]) & i_fpin_add[2];
        pin_drv |= mem_q[`APS_L_CLK] & i_fpin_add[3];
        pin_drv |= (live[`APS_L_CP] | mem_q[`APS_L_CP]) & i_fpin_add[4];
        pin_drv |= gwarn & i_fpin_add[5];
        pin_drv |= fsig & ~i_fsig_pin_off;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fault_oe_q <= 1'b0;
            fsig_q     <= 1'b0;
            wsig_q     <= 1'b0;
            gfault_q   <= 1'b0;
            gwarn_q    <= 1'b0;
            twarn_q    <= 1'b0;
        end else begin
            fault_oe_q <= pin_drv & ~clr;
            fsig_q     <= fsig;
            wsig_q     <= wsig;
            gfault_q   <= |fsrc;
            gwarn_q    <= gwarn;
            twarn_q    <= live[`APS_L_OTW];
        end
    end
    assign o_fault_o      = 1'b0;
    assign o_fault_oe     = fault_oe_q;
    assign o_fault_sig    = fsig_q;
    assign o_global_fault = gfault_q;
    assign o_warn_sig     = wsig_q;
    assign o_global_warn  = gwarn_q;
    assign o_temp_warn    = twarn_q;

    // configurable pins: function code OFF leaves the pin undriven
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            gpio_o_q  <= '0;
            gpio_oe_q <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                gpio_oe_q[p] <= 1'b0;
                gpio_o_q[p]  <= 1'b0;
                if (!clr) begin
                    unique case (i_gpio_func[p*`APS_FW +: `APS_FW])
                        `APS_F_FSIG: begin
                            gpio_oe_q[p] <= 1'b1;
                            gpio_o_q[p]  <= ~fsig;
                        end
                        `APS_F_WSIG: begin
                            gpio_oe_q[p] <= 1'b1;
                            gpio_o_q[p]  <= ~wsig;
                        end
                        `APS_F_CLKOUT: begin
                            gpio_oe_q[p] <= 1'b1;
                            gpio_o_q[p]  <= i_ss_en ? i_ss_clk : i_ramp_clk;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end
    assign o_gpio_o  = gpio_o_q;
    assign o_gpio_oe = gpio_oe_q;

    always_comb begin
        sync_src = 1'b0;
        if (i_sync_sel == `APS_S_SCLK) begin
            sync_src = i_sclk;
        end else if (i_sync_sel == `APS_S_PIN) begin
            if (i_gpio_func[`APS_FW-1:0] == `APS_F_SYNCIN) begin
                sync_src = i_gpio_i[0];
            end else if (i_gpio_func[2*`APS_FW-1:`APS_FW] == `APS_F_SYNCIN) begin
                sync_src = i_gpio_i[1];
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sync_q       <= 1'b0;
            sync_pulse_q <= 1'b0;
        end else begin
            sync_q       <= sync_src;
            sync_pulse_q <= sync_src & ~sync_q & ~clr;
        end
    end
    assign o_ramp_sync = sync_pulse_q;

    assign o_shutdown   = ~i_pd_n;
    assign o_deep_sleep = i_pd_n & ~i_standby_n_pin_n;
    assign o_prot_sd    = pwr_fail | i_digital_supply_por_off;

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        aps_pkg::aps_state_e st_q;
        logic [1:0]    req;
        logic          flt;
        logic          arec;
        logic          hot;
        logic [AW-1:0] ceil;
        logic [AW:0]   up;
        logic [AW-1:0] atten_q;
        logic [HW-1:0] hold_q;

        assign req  = i_st_req[2*c +: 2];
        assign flt  = i_ocsd_ch[c] | i_dc_ch[c] | i_live_flt_ch[c] | i_cp_fault
                    | ((i_overtemp_shutdown_ch[c] | i_overtemp_shutdown_glob) & ~i_overtemp_shutdown_self_recovery_state);
        assign arec = pwr_fail | i_clk_err
                    | ((i_overtemp_shutdown_ch[c] | i_overtemp_shutdown_glob) & i_overtemp_shutdown_self_recovery_state);

        // states FAULT and AREC come only from flt/arec or a failed DC diag, never from req
        always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
                st_q <= aps_pkg::ST_SLEEP;
            end else if (clr) begin
                st_q <= aps_pkg::ST_SLEEP;
            end else begin
                unique case (st_q)
                    aps_pkg::ST_LDG: begin
                        if (i_ldg_fail_ch[c]) begin
                            st_q <= aps_pkg::ST_FAULT;
                        end else if (i_ldg_pass_ch[c]) begin
                            st_q <= aps_pkg::ST_SLEEP;
                        end
                    end
                    aps_pkg::ST_SLEEP: begin
                        if (i_st_wr && req[1] && !i_clk_err) begin
                            st_q <= aps_pkg::ST_HIZ;
                        end else if (i_st_wr && req == `APS_R_LDG) begin
                            st_q <= aps_pkg::ST_LDG;
                        end
                    end
                    aps_pkg::ST_HIZ, aps_pkg::ST_PLAY: begin
                        if (flt) begin
                            st_q <= aps_pkg::ST_FAULT;
                        end else if (arec) begin
                            st_q <= aps_pkg::ST_AREC;
                        end else if (i_st_wr) begin
                            unique case (req)
                                `APS_R_PLAY:  st_q <= aps_pkg::ST_PLAY;
                                `APS_R_HIZ:   st_q <= aps_pkg::ST_HIZ;
                                `APS_R_SLEEP: st_q <= aps_pkg::ST_SLEEP;
                                `APS_R_LDG:   st_q <= aps_pkg::ST_LDG;
                            endcase
                        end
                    end
                    aps_pkg::ST_FAULT: begin
                        if (i_st_wr && !req[1]) begin
                            st_q <= req[0] ? aps_pkg::ST_SLEEP : aps_pkg::ST_LDG;
                        end
                    end
                    aps_pkg::ST_AREC: begin
                        if (flt) begin
                            st_q <= aps_pkg::ST_FAULT;
                        end else if (!arec) begin
                            st_q <= aps_pkg::ST_PLAY;
                        end
                    end
                    default: st_q <= aps_pkg::ST_SLEEP;
                endcase
            end
        end

        assign in_fault[c] = (st_q == aps_pkg::ST_FAULT);
        assign o_ch_state[3*c +: 3] = st_q;
        assign o_ch_switch[c] = (st_q == aps_pkg::ST_PLAY) & i_standby_n_pin_n & i_pd_n;
        assign o_ch_dsp[c] = ((st_q == aps_pkg::ST_PLAY) | (st_q == aps_pkg::ST_HIZ))
                           & i_standby_n_pin_n & i_pd_n;

        // highest hot level picks the ceiling; ceilings replace, never add
        always_comb begin
            hot  = 1'b0;
            ceil = '0;
            for (int l = 0; l < NLVL; l++) begin
                if (i_fb_hot[c*NLVL + l]) begin
                    hot  = 1'b1;
                    ceil = i_fb_max[l*AW +: AW];
                end
            end
        end
        assign up = {1'b0, atten_q} + {1'b0, i_fb_attack};

        always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
                atten_q <= '0;
                hold_q  <= '0;
            end else if (clr) begin
                atten_q <= '0;
                hold_q  <= '0;
            end else if (i_sample_stb) begin
                if (hot) begin
                    hold_q <= i_fb_hold;
                    if (atten_q > ceil || up > {1'b0, ceil}) begin
                        atten_q <= ceil;
                    end else begin
                        atten_q <= up[AW-1:0];
                    end
                end else if (hold_q != '0) begin
                    hold_q <= hold_q - 1'b1;
                end else if (atten_q > i_fb_release) begin
                    atten_q <= atten_q - i_fb_release;
                end else begin
                    atten_q <= '0;
                end
            end
        end
        assign o_fb_atten[c*AW +: AW] = atten_q;
    end
endmodule

// ===== aps_protect_ctrl_checker.sv
// Purpose: port checks of the protection and state control block
// Assumes: bound to aps_protect_ctrl, reset high
// Notes:   ok excludes cycles cleared by power-down or supply loss
`timescale 1ns/10ps
module aps_protect_ctrl_checker #(
    parameter int NCH  = 4,
    parameter int NLVL = 3,
    parameter int AW   = 10,
    parameter int HW   = 12
) (
    input logic                i_ref_clk, i_rst, i_pd_n, i_standby_n_pin_n, i_sample_stb, i_clk_err,
    input logic                i_vbat_uv, i_power_stage_supply_uv, i_power_stage_supply_ov, i_digital_supply_uv, i_cp_uv, i_st_wr,
    input logic                i_digital_supply_por_off, o_fault_o, o_fault_oe, o_prot_sd, o_shutdown,
    input logic [NCH-1:0]      i_dc_ch, o_ch_switch, o_ch_dsp,
    input logic [2:0]          i_fpin_mask,
    input logic [NCH*NLVL-1:0] i_fb_hot,
    input logic [NLVL*AW-1:0]  i_fb_max,
    input logic [2*NCH-1:0]    i_st_req,
    input logic [NCH*AW-1:0]   o_fb_atten,
    input logic [3*NCH-1:0]    o_ch_state
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire ok = i_pd_n & ~i_digital_supply_por_off;
    property p_od; !o_fault_o; endproperty
    a_od: assert property (p_od)
        else $error("fault pin driven high");
    property p_pd; !i_pd_n |-> o_shutdown ##1 o_ch_state == {NCH{3'h1}}; endproperty
    a_pd: assert property (p_pd)
        else $error("power-down did not restore defaults");
    property p_standby_n_pin; !i_standby_n_pin_n |-> o_ch_switch == '0 && o_ch_dsp == '0; endproperty
    a_standby_n_pin: assert property (p_standby_n_pin)
        else $error("channel active in deep sleep");
    property p_prot;
        i_vbat_uv || i_power_stage_supply_uv || i_power_stage_supply_ov || i_digital_supply_uv || i_cp_uv || i_digital_supply_por_off |-> o_prot_sd;
    endproperty
    a_prot: assert property (p_prot)
        else $error("supply fault without shutdown");
    property p_dc; (i_dc_ch != '0 && ok) ##1 (ok && !i_fpin_mask[2]) |=> o_fault_oe; endproperty
    a_dc: assert property (p_dc)
        else $error("dc event did not pull fault pin");
    property p_ceil;
        i_sample_stb && ok && i_fb_hot[NLVL-1:0] == NLVL'(1)
            |=> o_fb_atten[AW-1:0] <= $past(i_fb_max[AW-1:0]);
    endproperty
    a_ceil: assert property (p_ceil)
        else $error("attenuation above ceiling");
    property p_hiz;
        i_st_wr && i_st_req[1] && o_ch_state[2:0] == 3'h1 && !i_clk_err && ok && !o_prot_sd
            |=> o_ch_state[2:0] == 3'h2;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("sleep channel did not reach hi-z");
    property p_play; o_ch_switch[0] |-> o_ch_state[2:0] == 3'h3; endproperty
    a_play: assert property (p_play)
        else $error("switching outside play");
    c_play: cover property (o_ch_state[2:0] == 3'h3);
    c_pin: cover property ($rose(o_fault_oe));
    c_hot: cover property (i_sample_stb && i_fb_hot != '0);
endmodule
bind aps_protect_ctrl aps_protect_ctrl_checker #(.NCH(NCH), .NLVL(NLVL), .AW(AW), .HW(HW))
    u_chk (.*);

// ===== aps_protect_ctrl_tb_top.sv
// Purpose: self-checking bench of the protection and state control block
// Assumes: host model issues state writes, the bench drives the rest
// Notes:   foldback uses a random attack step and ceiling
`timescale 1ns/10ps
module aps_protect_ctrl_tb_top;
    logic        i_ref_clk = 0, i_rst = 1, i_pd_n = 1, i_standby_n_pin_n = 1, i_sample_stb = 0, go = 0;
    logic        i_otw_glob = 0, i_overtemp_shutdown_glob = 0, i_overtemp_shutdown_self_recovery_state = 0, i_cp_fault = 0, i_st_wr;
    logic        i_vbat_uv = 0, i_power_stage_supply_uv = 0, i_power_stage_supply_ov = 0, i_digital_supply_uv = 0, i_cp_uv = 0;
    logic        i_digital_supply_por_off = 0, i_clk_err = 0, i_fsig_pin_off = 0, i_ramp_clk = 0;
    logic        i_ss_clk = 0, i_ss_en = 0, i_sclk = 0, o_fault_o, o_fault_oe, o_global_fault;
    logic        o_fault_sig, o_global_warn, o_warn_sig, o_temp_warn, o_ramp_sync, o_prot_sd;
    logic        o_shutdown, o_deep_sleep;
    logic [11:0] i_fb_hot = 0, i_fb_hold = 0, o_ch_state;
    logic [29:0] i_fb_max = 0;
    logic [9:0]  i_fb_attack = 0, i_fb_release = 0, atk, cl, e;
    logic [3:0]  i_otw_ch = 0, i_overtemp_shutdown_ch = 0, i_ocsd_ch = 0, i_oclim_ch = 0, i_dc_ch = 0;
    logic [3:0]  i_live_flt_ch = 0, i_clip_ch = 0, i_ldg_pass_ch = 0, i_ldg_fail_ch = 0;
    logic [3:0]  o_ch_switch, o_ch_dsp;
    logic [8:0]  i_mem_clr = 0, i_fsig_en = 0, o_mem;
    logic [7:0]  i_wsig_en = 0, i_st_req, code = 0;
    logic [5:0]  i_fpin_add = 0, i_gpio_func = 0;
    logic [2:0]  i_fpin_mask = 0;
    logic [1:0]  i_gpio_i = 0, i_sync_sel = 0, o_gpio_o, o_gpio_oe;
    logic [39:0] o_fb_atten;
    int          errors = 0, cmp_count = 0, cycles = 0;
    aps_protect_ctrl u_dut (.*);
    aps_host_model u_host (.i_ref_clk(i_ref_clk), .i_go(go), .i_code(code),
                           .o_st_wr(i_st_wr), .o_st_req(i_st_req));
    always #10 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        {i_ramp_clk, i_ss_clk, i_sclk} <= 3'($urandom);
        if (cycles == 5000) begin
            errors = errors + 1;
            test_done();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic smp();
        i_sample_stb <= 1'b1;
        cyc(1);
        i_sample_stb <= 1'b0;
        cyc(1);
    endtask
    task automatic wr(input logic [7:0] c);
        {go, code} <= {1'b1, c};
        cyc(1);
        go <= 1'b0;
        cyc(2);
    endtask
    task automatic chk(input logic [39:0] s, input logic [39:0] x);
        cmp_count++;
        if (s !== x) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    function automatic logic [9:0] f_atk(input logic [9:0] a, s, c);
        return (a + s > c) ? c : a + s;
    endfunction
    task automatic test_done();
        $display("compares=%0d mismatches=%0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        void'($urandom(17943));
        cyc(10);
        i_rst <= 1'b0;
        cyc(1);
        chk({o_gpio_oe, o_fault_oe}, 3'h0);
        atk = 10'($urandom_range(15, 1));
        cl = 10'($urandom_range(60, 1));
        {i_fb_attack, i_fb_max, i_fb_hot} <= {atk, 20'h0, cl, 12'h001};
        e = 10'h000;
        repeat (6) begin
            smp();
            e = f_atk(e, atk, cl);
            chk(o_fb_atten[9:0], e);
        end
        {i_fb_max, i_fb_hot, i_fb_release, i_fb_hold} <= {30'h0000100C, 12'h003, 10'h002, 12'h002};
        smp();
        e = f_atk(e, atk, 10'h004);
        chk(o_fb_atten[9:0], e);
        i_fb_hot <= 12'h000;
        for (int k = 0; k < 4; k++) begin
            smp();
            if (k > 1) e = (e > 10'h002) ? e - 10'h002 : 10'h000;
            chk(o_fb_atten[9:0], e);
        end
        $display("foldback test done");
        i_dc_ch <= 4'h1;
        cyc(1);
        i_dc_ch <= 4'h0;
        cyc(1);
        chk({o_mem[2], o_global_fault, o_fault_oe}, 3'h7);
        i_fpin_mask <= 3'h4;
        cyc(2);
        chk({o_mem[2], o_global_fault, o_fault_oe}, 3'h6);
        i_fsig_en <= 9'h010;
        cyc(2);
        chk({o_fault_sig, o_fault_oe}, 2'h3);
        {i_fsig_en, i_fpin_add, i_vbat_uv} <= 16'h0003;
        cyc(2);
        chk(o_fault_oe, 1'b1);
        {i_fpin_add, i_vbat_uv, i_mem_clr} <= 16'h01FF;
        cyc(1);
        {i_mem_clr, i_clip_ch, i_wsig_en, i_gpio_func} <= {9'h000, 4'h2, 8'h20, 6'h0A};
        cyc(1);
        i_clip_ch <= 4'h0;
        cyc(2);
        chk({o_global_warn, o_warn_sig, o_gpio_oe, o_gpio_o}, 6'h3E);
        {i_mem_clr, i_wsig_en, i_gpio_func} <= {9'h1FF, 8'h00, 6'h00};
        cyc(1);
        {i_mem_clr, i_clk_err} <= {9'h000, 1'b1};
        cyc(1);
        i_clk_err <= 1'b0;
        cyc(2);
        chk({o_mem, o_global_warn}, 10'h020);
        {i_otw_glob, i_otw_ch} <= 5'h04;
        cyc(1);
        chk(o_temp_warn, 1'b1);
        $display("reporting test done");
        {i_otw_ch, i_clk_err, i_mem_clr} <= {4'h0, 1'b1, 9'h1FF};
        wr(8'hFF);
        chk(o_ch_state, 12'h249);
        {i_clk_err, i_mem_clr} <= 10'h000;
        wr(8'hAA);
        chk({o_ch_state, o_ch_dsp, o_ch_switch}, 20'h492F0);
        wr(8'hFF);
        chk({o_ch_state, o_ch_switch}, 16'h6DBF);
        i_standby_n_pin_n <= 1'b0;
        cyc(1);
        chk({o_deep_sleep, o_ch_switch, o_ch_dsp}, 9'h100);
        {i_standby_n_pin_n, i_ocsd_ch, i_overtemp_shutdown_ch, i_overtemp_shutdown_self_recovery_state} <= 10'h225;
        cyc(1);
        chk(o_ch_state, 12'h6EC);
        {i_ocsd_ch, i_overtemp_shutdown_ch} <= 8'h00;
        cyc(2);
        chk(o_ch_state, 12'h6DC);
        wr(8'hFF);
        chk(o_ch_state[2:0], 3'h4);
        wr(8'h00);
        i_ldg_pass_ch <= 4'h1;
        cyc(1);
        i_ldg_pass_ch <= 4'h0;
        cyc(1);
        chk(o_ch_state[2:0], 3'h1);
        i_pd_n <= 1'b0;
        cyc(1);
        chk({o_shutdown, o_ch_state, o_mem}, 22'h249200);
        i_pd_n <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            {i_vbat_uv, i_power_stage_supply_uv, i_power_stage_supply_ov, i_digital_supply_uv, i_cp_uv, i_digital_supply_por_off} <= 6'h01 << k;
            cyc(1);
            chk(o_prot_sd, 1'b1);
        end
        // pin 0 shares the ramp clock, pin 1 is the sync input
        {i_gpio_func, i_sync_sel} <= {6'h23, 2'h1};
        for (int k = 0; k < 4; k++) begin
            {i_ss_en, i_gpio_i} <= {k[0], k[1], 1'b0};
            cyc(1);
            chk(o_ramp_sync, k == 2);
            e = {9'h000, i_ss_en ? i_ss_clk : i_ramp_clk};
            cyc(1);
            chk(o_gpio_o[0], e);
        end
        repeat (50) begin
            {i_live_flt_ch, i_oclim_ch, i_cp_fault, i_overtemp_shutdown_glob, i_ldg_fail_ch, i_fsig_pin_off,
             i_sync_sel, i_ss_en, i_gpio_i, i_digital_supply_por_off} <= 21'($urandom) & 21'h1FFFFE;
            cyc(1);
        end
        $display("state test done");
        test_done();
    end
endmodule
